// [hdl/dsr_pkg.sv]
// dsr_pkg: shared constants and types of the four-channel dma suspend block
// assumes: one clock domain, channels served one at a time
package dsr_pkg;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned CH_W        = 2;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned FIFO_DEPTH  = 16;
  // transfer size select encoding
  localparam logic        SIZE_8BIT   = 1'h0;
  localparam logic        SIZE_16BIT  = 1'h1;
  // address direction encoding
  localparam logic [1:0]  DIR_INC     = 2'h0;
  localparam logic [1:0]  DIR_DEC     = 2'h1;
  localparam logic [1:0]  DIR_FIX     = 2'h2;
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
  // cycles one unit spends in the move stage
  localparam int unsigned MOVE_CYC    = 1;

  typedef enum logic [1:0] {
    DSR_IDLE,
    DSR_MOVE,
    DSR_DONE
  } dsr_state_t;
endpackage : dsr_pkg

// [hdl/dsr_if.sv]
// dsr_if: link between the channel engine and the request-source side
// assumes: both ends clocked by the same clk
`timescale 1ns/10ps
`default_nettype none
interface dsr_if (
  input wire logic clk,
  input wire logic rstn
);
  // per-channel peripheral requests and software channel bits
  logic [dsr_pkg::NUM_CH-1:0] req;
  logic [dsr_pkg::NUM_CH-1:0] enable;
  logic [dsr_pkg::NUM_CH-1:0] request_pending_flag;
  logic [dsr_pkg::NUM_CH-1:0] transfer_complete_flag;
  logic [dsr_pkg::NUM_CH-1:0] tc_clear;
  // moved data units toward the sink
  logic                       xfer_valid;
  logic                       xfer_ready;
  logic [dsr_pkg::DATA_W-1:0] xfer_data;
  logic [dsr_pkg::ADDR_W-1:0] xfer_dst;

  modport engine (
    input  clk, rstn, req, enable, tc_clear, xfer_ready,
    output request_pending_flag, transfer_complete_flag,
    output xfer_valid, xfer_data, xfer_dst
  );
  modport source (
    input  clk, rstn, request_pending_flag, transfer_complete_flag,
    input  xfer_valid, xfer_data, xfer_dst,
    output req, enable, tc_clear, xfer_ready
  );
endinterface : dsr_if
`default_nettype wire

// [hdl/dsr_fifo.sv]
// dsr_fifo: parameterised synchronous fifo on the moved-data path
// assumes: single clock, valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dsr_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW:0]      wp_ff;
  logic [PW:0]      rp_ff;
  wire              full  = (wp_ff[PW] != rp_ff[PW]) &&
                            (wp_ff[PW-1:0] == rp_ff[PW-1:0]);
  wire              empty = (wp_ff == rp_ff);
  wire              push  = in_valid && !full;
  wire              pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_ff[rp_ff[PW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop)  rp_ff <= rp_ff + 1'b1;
    end
  end
endmodule : dsr_fifo
`default_nettype wire

// [hdl/dsr_engine.sv]
// dsr_engine: four-channel dma engine with suspend and resume by enable
// Contract
// - software stops request source before suspend
// - pending flag is 1 while request waits
// - pending request still served; software waits
// - completion flag set when transfer finishes
// - enable 0 without pending suspends channel
// - enable 1 resumes from where it stopped
// - software restarts request source after resume
// - 16-bit odd addresses forced even
// - software keeps addresses inside their area
// - size select: 0 byte, 1 halfword
// - four independent channels 0 to 3
// assumes: channel setup ports written while the channel is disabled;
// the data path carries a pattern taken from the source address, memory itself lives outside.
`timescale 1ns/10ps
`default_nettype none
module dsr_engine (
  // link
  dsr_if.engine                                     lnk,
  // per-channel setup
  input  wire logic [dsr_pkg::NUM_CH-1:0]           setup_we,
  input  wire logic [dsr_pkg::ADDR_W-1:0]           setup_src,
  input  wire logic [dsr_pkg::ADDR_W-1:0]           setup_dst,
  input  wire logic [dsr_pkg::CNT_W-1:0]            setup_cnt,
  input  wire logic                                 setup_size,
  input  wire logic [1:0]                           setup_sdir,
  input  wire logic [1:0]                           setup_ddir,
  // status
  output logic [dsr_pkg::NUM_CH-1:0]                suspended,
  output logic [dsr_pkg::NUM_CH*dsr_pkg::CNT_W-1:0] remain_cnt
);
  localparam int unsigned N  = dsr_pkg::NUM_CH;
  localparam int unsigned AW = dsr_pkg::ADDR_W;
  localparam int unsigned CW = dsr_pkg::CNT_W;
  localparam int unsigned FW = dsr_pkg::DATA_W + AW;

  function automatic logic [AW-1:0] step_addr(
    input logic [AW-1:0] a, input logic [1:0] dir, input logic sz);
    logic [AW-1:0] inc;
    inc = (sz == dsr_pkg::SIZE_16BIT) ? 32'h0000_0002 : 32'h0000_0001;
    case (dir)
      dsr_pkg::DIR_INC: step_addr = a + inc;
      dsr_pkg::DIR_DEC: step_addr = a - inc;
      default:          step_addr = a;
    endcase
  endfunction : step_addr

  // 16-bit units ignore bit 0 of the address
  function automatic logic [AW-1:0] align(
    input logic [AW-1:0] a, input logic sz);
    align = (sz == dsr_pkg::SIZE_16BIT) ? {a[AW-1:1], 1'b0} : a;
  endfunction : align

  localparam int unsigned DW = dsr_pkg::DATA_W;
  wire                    clk_w = lnk.clk;

  // per-channel setup and progress
  logic [N-1:0]        pend_ff;
  logic [N-1:0]        tc_ff;
  logic [N-1:0]        size_ff;
  logic [1:0]          sdir_ff [N];
  logic [1:0]          ddir_ff [N];
  logic [AW-1:0]       src_ff  [N];
  logic [AW-1:0]       dst_ff  [N];
  logic [CW-1:0]       cnt_ff  [N];
  // shared service stage
  logic [1:0]          ch_ff;
  logic [1:0]          nxt_ch;
  dsr_pkg::dsr_state_t st_ff;
  dsr_pkg::dsr_state_t nxt_st;

  // arbiter: lowest channel number with a pending request, enable and no completion flag
  logic [N-1:0] serve_req;
  logic         any_req;
  logic [1:0]   pick;
  assign serve_req = pend_ff & lnk.enable & ~tc_ff;
  assign any_req   = |serve_req;
  always_comb begin
    pick = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (serve_req[i]) begin
        pick = 2'(i);
      end
    end
  end

  // one unit in flight at a time: pick, move, then a rest cycle
  logic fifo_ready;
  wire  in_move = (st_ff == dsr_pkg::DSR_MOVE);
  wire  do_move = in_move && fifo_ready;

  always_comb begin
    nxt_st = st_ff;
    nxt_ch = ch_ff;
    case (st_ff)
      dsr_pkg::DSR_IDLE: begin
        if (any_req) begin
          nxt_st = dsr_pkg::DSR_MOVE;
          nxt_ch = pick;
        end
      end
      // a started unit finishes even if the enable drops meanwhile
      dsr_pkg::DSR_MOVE: begin
        if (fifo_ready) begin
          nxt_st = dsr_pkg::DSR_DONE;
        end
      end
      default: begin
        nxt_st = dsr_pkg::DSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_w or negedge lnk.rstn) begin
    if (!lnk.rstn) begin
      st_ff <= dsr_pkg::DSR_IDLE;
      ch_ff <= 2'h0;
    end else begin
      st_ff <= nxt_st;
      ch_ff <= nxt_ch;
    end
  end

  // head unit of the channel in service
  wire          cur_size  = size_ff[ch_ff];
  wire [AW-1:0] cur_src   = align(src_ff[ch_ff], cur_size);
  wire [AW-1:0] cur_dst   = align(dst_ff[ch_ff], cur_size);
  // data pattern: byte units carry only the low byte
  wire [DW-1:0] byte_data = {8'h00, cur_src[7:0]};
  wire [DW-1:0] half_data = cur_src[DW-1:0];
  wire [DW-1:0] cur_data  = (cur_size == dsr_pkg::SIZE_8BIT)
                            ? byte_data : half_data;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      wire          mine_move = do_move && (ch_ff == 2'(g));
      wire          last_unit = (cnt_ff[g] == 16'h0001);
      wire          load      = setup_we[g];
      // a new request wins over the clear by service
      wire          nxt_pend  = lnk.req[g] || (pend_ff[g] && !mine_move);
      // completion wins over a clear in the same cycle
      wire          set_tc    = mine_move && last_unit;
      wire          clr_tc    = lnk.tc_clear[g] || load;
      wire          nxt_tc    = set_tc || (tc_ff[g] && !clr_tc);
      // only a served unit steps these, so a suspend freezes them
      wire [AW-1:0] src_step  = step_addr(src_ff[g], sdir_ff[g], size_ff[g]);
      wire [AW-1:0] dst_step  = step_addr(dst_ff[g], ddir_ff[g], size_ff[g]);
      wire [CW-1:0] cnt_step  = cnt_ff[g] - 16'h0001;
      wire [AW-1:0] kept_src  = mine_move ? src_step : src_ff[g];
      wire [AW-1:0] kept_dst  = mine_move ? dst_step : dst_ff[g];
      wire [CW-1:0] kept_cnt  = mine_move ? cnt_step : cnt_ff[g];
      wire          nxt_size  = load ? setup_size : size_ff[g];
      wire [1:0]    nxt_sdir  = load ? setup_sdir : sdir_ff[g];
      wire [1:0]    nxt_ddir  = load ? setup_ddir : ddir_ff[g];
      wire [AW-1:0] nxt_src   = load ? setup_src  : kept_src;
      wire [AW-1:0] nxt_dst   = load ? setup_dst  : kept_dst;
      wire [CW-1:0] nxt_cnt   = load ? setup_cnt  : kept_cnt;

      always_ff @(posedge clk_w or negedge lnk.rstn) begin
        if (!lnk.rstn) begin
          pend_ff[g] <= 1'b0;
          tc_ff[g]   <= 1'b0;
        end else begin
          pend_ff[g] <= nxt_pend;
          tc_ff[g]   <= nxt_tc;
        end
      end

      always_ff @(posedge clk_w or negedge lnk.rstn) begin
        if (!lnk.rstn) begin
          size_ff[g] <= dsr_pkg::SIZE_8BIT;
          sdir_ff[g] <= dsr_pkg::DIR_INC;
          ddir_ff[g] <= dsr_pkg::DIR_INC;
          src_ff[g]  <= dsr_pkg::ADDR_RST;
          dst_ff[g]  <= dsr_pkg::ADDR_RST;
          cnt_ff[g]  <= dsr_pkg::CNT_RST;
        end else begin
          size_ff[g] <= nxt_size;
          sdir_ff[g] <= nxt_sdir;
          ddir_ff[g] <= nxt_ddir;
          src_ff[g]  <= nxt_src;
          dst_ff[g]  <= nxt_dst;
          cnt_ff[g]  <= nxt_cnt;
        end
      end

      // resumes with the held addresses as soon as enable returns
      assign suspended[g] = !lnk.enable[g] && !tc_ff[g];
      assign remain_cnt[g*CW +: CW] = cnt_ff[g];
    end
  endgenerate

  assign lnk.request_pending_flag   = pend_ff;
  assign lnk.transfer_complete_flag = tc_ff;

  // a fifo word holds the data above the destination address
  wire [FW-1:0] fifo_in = {cur_data, cur_dst};
  wire [FW-1:0] fifo_out;

  dsr_fifo #(
    .WIDTH (FW),
    .DEPTH (dsr_pkg::FIFO_DEPTH)
  ) dsr_fifo_i (
    .clk       (clk_w),
    .rstn      (lnk.rstn),
    .in_valid  (in_move),
    .in_ready  (fifo_ready),
    .in_data   (fifo_in),
    .out_valid (lnk.xfer_valid),
    .out_ready (lnk.xfer_ready),
    .out_data  (fifo_out)
  );

  assign lnk.xfer_data = fifo_out[FW-1:AW];
  assign lnk.xfer_dst  = fifo_out[AW-1:0];
endmodule : dsr_engine
`default_nettype wire

// [hdl/dsr_source.sv]
// dsr_source: software and peripheral side; runs the suspend sequence
// assumes: user pulses for suspend and resume per channel
`timescale 1ns/10ps
`default_nettype none
module dsr_source (
  // link
  dsr_if.source                          lnk,
  // user side
  input  wire logic [dsr_pkg::NUM_CH-1:0] periph_req,
  input  wire logic [dsr_pkg::NUM_CH-1:0] start_ch,
  input  wire logic [dsr_pkg::NUM_CH-1:0] suspend_cmd,
  input  wire logic [dsr_pkg::NUM_CH-1:0] resume_cmd,
  input  wire logic                       sink_ready,
  output logic [dsr_pkg::NUM_CH-1:0]      src_running,
  output logic [dsr_pkg::NUM_CH-1:0]      done_seen
);
  localparam int unsigned N = dsr_pkg::NUM_CH;
  logic [N-1:0] en_ff;
  logic [N-1:0] run_ff;
  logic [N-1:0] wait_ff;
  logic [N-1:0] done_ff;
  logic [N-1:0] clr_ff;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      wire tc = lnk.transfer_complete_flag[g];
      wire pd = lnk.request_pending_flag[g];
      always_ff @(posedge lnk.clk or negedge lnk.rstn) begin
        if (!lnk.rstn) begin
          en_ff[g]   <= 1'b0;
          run_ff[g]  <= 1'b0;
          wait_ff[g] <= 1'b0;
          done_ff[g] <= 1'b0;
          clr_ff[g]  <= 1'b0;
        end else begin
          clr_ff[g] <= 1'b0;
          if (start_ch[g] || resume_cmd[g]) begin
            en_ff[g]  <= 1'b1;
            run_ff[g] <= 1'b1;
          end else if (suspend_cmd[g]) begin
            run_ff[g]  <= 1'b0;
            wait_ff[g] <= 1'b1;
          end else if (wait_ff[g] && !pd) begin
            wait_ff[g] <= 1'b0;
            if (tc) begin
              done_ff[g] <= 1'b1;
              clr_ff[g]  <= 1'b1;
            end else begin
              en_ff[g] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  assign lnk.enable     = en_ff;
  // peripheral requests reach the engine only while the source runs
  assign lnk.req        = periph_req & run_ff;
  assign lnk.tc_clear   = clr_ff;
  assign lnk.xfer_ready = sink_ready;
  assign src_running    = run_ff;
  assign done_seen      = done_ff;
endmodule : dsr_source
`default_nettype wire

// [dv/dsr_checker.sv]
// dsr_checker: timing checks on the link, channel 0 and the shared path
// assumes: placed beside the link in the bench, one clock domain
`timescale 1ns/10ps
`default_nettype none
module dsr_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // link signals
  input wire logic [3:0]  req,
  input wire logic [3:0]  enable,
  input wire logic [3:0]  request_pending_flag,
  input wire logic [3:0]  transfer_complete_flag,
  input wire logic [3:0]  tc_clear,
  input wire logic        xfer_valid,
  input wire logic        xfer_ready,
  input wire logic [15:0] xfer_data,
  input wire logic [31:0] xfer_dst
);
  logic [3:0] pend_ff;
  logic       served;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pend_ff <= 4'h0;
    else pend_ff <= request_pending_flag;
  end
  // a dropped pending bit means one unit left the move stage
  assign served = |(pend_ff & ~request_pending_flag);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pend_sets: assert property (req[0] |=> request_pending_flag[0])
    else $error("pending flag missed a request");
  a_pend_cause: assert property (!req[0] && !request_pending_flag[0]
    |=> !request_pending_flag[0]) else $error("pending without request");
  a_serve_en: assert property ($fell(request_pending_flag[0])
    |-> $past(enable[0])) else $error("unit moved while disabled");
  a_tc_cause: assert property ($rose(transfer_complete_flag[0])
    |-> $past(request_pending_flag[0])) else $error("done without unit");
  a_tc_clears: assert property (tc_clear[0]
    |=> !transfer_complete_flag[0]) else $error("done flag not cleared");
  a_hold_unit: assert property (xfer_valid && !xfer_ready
    |=> xfer_valid && $stable(xfer_data) && $stable(xfer_dst))
    else $error("offered unit changed");
  a_unit_gap: assert property (served |=> !served [*2])
    else $error("units closer than three cycles");
  a_drop_idle: assert property ($fell(enable[0])
    |-> !$past(request_pending_flag[0])) else $error("disabled while held");
  c_served: cover property (served);
  c_suspend: cover property ($fell(enable[0]));
  c_clear: cover property (tc_clear[0]);
  c_stall: cover property (xfer_valid && !xfer_ready);
endmodule : dsr_checker
`default_nettype wire

// [dv/dsr_channel_suspend_resume_test.sv]
// dma_channel_suspend_resume_test: engine and source joined by the link
// assumes: units leave the fifo in request order, one channel busy at once
`timescale 1ns/10ps
`default_nettype none
module dma_channel_suspend_resume_test;
  logic        clk = 1'b0, rstn = 1'b0, sz = 1'b0, rnd_en = 1'b1;
  logic        setup_size = 1'b0, sink_ready = 1'b0;
  logic [3:0]  setup_we = 4'h0, periph_req = 4'h0, start_ch = 4'h0;
  logic [3:0]  suspend_cmd = 4'h0, resume_cmd = 4'h0;
  logic [3:0]  suspended, src_running, done_seen;
  logic [31:0] setup_src = 32'h0, setup_dst = 32'h0, lfsr = 32'hDE7C4670;
  logic [31:0] sa, da;
  logic [15:0] setup_cnt = 16'h0;
  logic [1:0]  setup_sdir = 2'h0, setup_ddir = 2'h0, sd, dd;
  logic [63:0] remain_cnt;
  logic [47:0] exp_q[$];
  int          mismatches = 0, checks = 0;
  always #4 clk = ~clk;
  dsr_if dsr_if_i (.clk(clk), .rstn(rstn));
  dsr_engine dsr_engine_i (.lnk(dsr_if_i), .setup_we(setup_we),
    .setup_src(setup_src), .setup_dst(setup_dst), .setup_cnt(setup_cnt),
    .setup_size(setup_size), .setup_sdir(setup_sdir),
    .setup_ddir(setup_ddir), .suspended(suspended), .remain_cnt(remain_cnt));
  dsr_source dsr_source_i (.lnk(dsr_if_i), .periph_req(periph_req),
    .start_ch(start_ch), .suspend_cmd(suspend_cmd), .resume_cmd(resume_cmd),
    .sink_ready(sink_ready), .src_running(src_running),
    .done_seen(done_seen));
  dsr_checker dsr_checker_i (.clk(clk), .rstn(rstn), .req(dsr_if_i.req),
    .enable(dsr_if_i.enable), .tc_clear(dsr_if_i.tc_clear),
    .request_pending_flag(dsr_if_i.request_pending_flag),
    .transfer_complete_flag(dsr_if_i.transfer_complete_flag),
    .xfer_valid(dsr_if_i.xfer_valid), .xfer_ready(dsr_if_i.xfer_ready),
    .xfer_data(dsr_if_i.xfer_data), .xfer_dst(dsr_if_i.xfer_dst));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  always @(posedge clk) begin
    lfsr <= lfsr_next(lfsr);
    sink_ready <= rnd_en & lfsr[0];
  end
  task automatic cmp(input string what, input logic [47:0] e,
                     input logic [47:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic cmp_unit(input logic [47:0] e, input logic [47:0] g);
    cmp("unit", e, g);
  endtask : cmp_unit
  always @(posedge clk) begin
    if (rstn && dsr_if_i.xfer_valid && dsr_if_i.xfer_ready) begin
      if (exp_q.size() == 0) cmp("extra unit", 48'h0, 48'h1);
      else begin
        cmp_unit(exp_q.pop_front(),
                 {dsr_if_i.xfer_dst, dsr_if_i.xfer_data});
      end
    end
  end
  function automatic logic [31:0] step(input logic [31:0] a,
                                       input logic [1:0] d);
    logic [31:0] inc;
    inc = sz ? 32'h2 : 32'h1;
    return d == 2'h0 ? a + inc : d == 2'h1 ? a - inc : a;
  endfunction : step
  task automatic setup(input int ch, input logic [15:0] n, input logic s);
    sz = s;
    sa = (lfsr | 32'h1) & ~{31'h0, s};
    da = (lfsr[30:0] << 1 | 32'h1) & ~{31'h0, s};
    // direction code 3 is prohibited, so it becomes fixed
    sd = {lfsr[3], lfsr[2] & ~lfsr[3]};
    dd = {lfsr[5], lfsr[4] & ~lfsr[5]};
    setup_we <= 4'h1 << ch;
    setup_src <= lfsr | 32'h1;
    setup_dst <= lfsr[30:0] << 1 | 32'h1;
    setup_cnt <= n;
    setup_size <= s;
    setup_sdir <= sd;
    setup_ddir <= dd;
    @(posedge clk);
    setup_we <= 4'h0;
    start_ch <= 4'h1 << ch;
    @(posedge clk);
    start_ch <= 4'h0;
  endtask : setup
  // one request; with susp set the suspend arrives in the same cycle
  task automatic unit(input int ch, input logic susp);
    logic [15:0] left;
    left = remain_cnt[16*ch +: 16];
    exp_q.push_back({da, sz ? {sa[15:1], 1'b0} : {8'h00, sa[7:0]}});
    sa = step(sa, sd);
    da = step(da, dd);
    periph_req <= 4'h1 << ch;
    suspend_cmd <= {3'h0, susp} << ch;
    @(posedge clk);
    periph_req <= 4'h0;
    suspend_cmd <= 4'h0;
    for (int i = 0; i < 40 && remain_cnt[16*ch +: 16] === left; i++) begin
      @(posedge clk);
    end
  endtask : unit
  task automatic drain();
    for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge clk);
    cmp("units left", 48'h0, exp_q.size());
  endtask : drain
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // stalled sink: sixteen units fill the fifo, the next one must wait
    rnd_en <= 1'b0;
    setup(0, 16'h11, 1'b1);
    repeat (17) unit(0, 1'b0);
    cmp("count at full", 48'h1, remain_cnt[15:0]);
    rnd_en <= 1'b1;
    drain();
    $display("test fill and drain done");
    for (int ch = 0; ch < 4; ch++) begin
      setup(ch, 16'h6, ch[0]);
      unit(ch, 1'b0);
      unit(ch, 1'b0);
      unit(ch, 1'b1);
      repeat (6) @(posedge clk);
      cmp("suspended", 48'h1, suspended[ch]);
      periph_req <= 4'h1 << ch;
      repeat (20) @(posedge clk);
      periph_req <= 4'h0;
      cmp("held count", 48'h3, remain_cnt[16*ch +: 16]);
      resume_cmd <= 4'h1 << ch;
      @(posedge clk);
      resume_cmd <= 4'h0;
      repeat (3) @(posedge clk);
      cmp("resumed", 48'h3, {src_running[ch], dsr_if_i.enable[ch]});
      repeat (3) unit(ch, 1'b0);
      drain();
      cmp("done flag", 48'h1, dsr_if_i.transfer_complete_flag[ch]);
      suspend_cmd <= 4'h1 << ch;
      @(posedge clk);
      suspend_cmd <= 4'h0;
      repeat (10) @(posedge clk);
      cmp("done seen", 48'h2, {done_seen[ch], dsr_if_i.transfer_complete_flag[ch]});
      $display("test channel %0d done", ch);
    end
    results();
  end
endmodule : dma_channel_suspend_resume_test
`default_nettype wire
